// [rtl/adc_conversion_host_interface.sv]
// conversion start, busy/interrupt and read-back logic of a 12-bit converter
`timescale 1ns/1ns
`default_nettype none
`include "adc_host_defines.svh"

module adc_conversion_host_interface #(
  parameter int CONV_CYCLES = `CONV_CYCLES,
  parameter int SCLK_DIV = `SCLK_DIV
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // host pins, asynchronous
  input wire adc_host_pkg::host_ctl_t host_ctl,
  // converted sample from the analog core
  input wire logic [`RESULT_BITS-1:0] sample_code,
  // parallel data bus
  output logic [`RESULT_BITS-1:0] data_bus,
  output logic data_bus_oe,
  // status pin: busy in processor mode, interrupt in timer mode
  output logic busy_int_n,
  // sampling stage control, high while holding
  output logic track_hold,
  // serial lines as open-drain triples
  output adc_host_pkg::serial_out_t serial_out,
  output adc_host_pkg::serial_out_t serial_oe,
  // serial clock keeps running between frames
  input wire logic sclk_continuous
);

  adc_host_pkg::host_ctl_t meta_ff, sync_ff, prev_ff;
  adc_host_pkg::conv_state_t state_ff;
  logic [$clog2(CONV_CYCLES+1)-1:0] conv_cnt_ff;
  logic [`RESULT_BITS-1:0] result_ff;
  logic [`SERIAL_BITS-1:0] shift_ff;
  logic [4:0] bit_cnt_ff;
  localparam int DIV_W = $clog2(SCLK_DIV);
  logic [DIV_W-1:0] div_ff;
  logic sclk_cont_meta_ff, sclk_cont_ff;
  logic sclk_ff, frame_ff, high_byte_enable_ff, proc_mode_ff, stretch_ff, int_n_ff;
  logic [`RESULT_BITS-1:0] nxt_data;

  // two-flop synchroniser for every host pin
  always_ff @(posedge ref_clk) begin
    meta_ff <= host_ctl;
    sync_ff <= meta_ff;
    prev_ff <= sync_ff;
  end

  // clock mode pin is a level from outside; synchronised like the rest
  always_ff @(posedge ref_clk) begin
    sclk_cont_meta_ff <= sclk_continuous;
    sclk_cont_ff <= sclk_cont_meta_ff;
  end

  wire cs_fall = prev_ff.select_n & ~sync_ff.select_n;
  wire cvs_rise = ~prev_ff.convert_start_n & sync_ff.convert_start_n;
  wire rd_active = ~sync_ff.select_n & ~sync_ff.read_n;
  wire rd_fall = rd_active & ~(~prev_ff.select_n & ~prev_ff.read_n);
  // processor mode: start pin held low, cs with high_byte_enable low starts
  wire proc_start = (state_ff == adc_host_pkg::ST_IDLE) & cs_fall
    & sync_ff.convert_start_n == 1'b0 & ~sync_ff.high_byte_enable;
  // timer mode: rising start edge, ignored while cs low
  wire timer_start = (state_ff == adc_host_pkg::ST_IDLE) & cvs_rise & sync_ff.select_n;
  wire start = proc_start | timer_start;
  wire conv_end = (state_ff == adc_host_pkg::ST_CONVERT) && conv_cnt_ff == CONV_CYCLES - 1;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff <= adc_host_pkg::ST_IDLE;
      conv_cnt_ff <= '0;
      proc_mode_ff <= 1'b0;
    end else begin
      case (state_ff)
        adc_host_pkg::ST_IDLE: begin
          conv_cnt_ff <= '0;
          if (start) begin
            state_ff <= adc_host_pkg::ST_CONVERT;
            proc_mode_ff <= proc_start;
          end
        end
        adc_host_pkg::ST_CONVERT: begin
          conv_cnt_ff <= conv_cnt_ff + 1'b1;
          if (conv_end) begin
            state_ff <= adc_host_pkg::ST_DONE;
          end
        end
        adc_host_pkg::ST_DONE: begin
          // return to tracking; next start needs a fresh edge
          state_ff <= adc_host_pkg::ST_IDLE;
        end
        default: state_ff <= adc_host_pkg::ST_IDLE;
      endcase
    end
  end

  // hold from the start edge to the end of conversion
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      track_hold <= 1'b0;
    end else if (start) begin
      track_hold <= 1'b1;
    end else if (conv_end) begin
      track_hold <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      result_ff <= '0;
    end else if (conv_end) begin
      result_ff <= sample_code;
    end
  end

  // byte select latched at select fall
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      high_byte_enable_ff <= 1'b0;
    end else if (cs_fall) begin
      high_byte_enable_ff <= sync_ff.high_byte_enable;
    end
  end

  // stretch only the conversion-starting access
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stretch_ff <= 1'b0;
    end else if (proc_start) begin
      stretch_ff <= 1'b1;
    end else if (state_ff != adc_host_pkg::ST_CONVERT) begin
      stretch_ff <= 1'b0;
    end
  end

  // timer-mode interrupt: set wins over the read clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      int_n_ff <= 1'b1;
    end else if (conv_end & ~proc_mode_ff) begin
      int_n_ff <= 1'b0;
    end else if (rd_fall) begin
      int_n_ff <= 1'b1;
    end
  end

  // busy low for the whole processor conversion
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_int_n <= 1'b1;
    end else if (proc_start | (stretch_ff & state_ff == adc_host_pkg::ST_CONVERT & ~conv_end)) begin
      busy_int_n <= 1'b0;
    end else if (proc_mode_ff | state_ff == adc_host_pkg::ST_IDLE & proc_start) begin
      busy_int_n <= 1'b1;
    end else begin
      busy_int_n <= int_n_ff;
    end
  end

  // output mux: word, low byte, or right-justified nibble
  always_comb begin
    nxt_data = '0;
    if (sync_ff.word_format) begin
      nxt_data = conv_end ? sample_code : result_ff;
    end else if (high_byte_enable_ff) begin
      nxt_data = {{`BYTE_BITS{1'b0}}, result_ff[`RESULT_BITS-1:`BYTE_BITS]};
    end else begin
      nxt_data = {4'h0, (conv_end ? sample_code[`BYTE_BITS-1:0] : result_ff[`BYTE_BITS-1:0])};
    end
  end

  // bus output enable held off during conversion; host must not read then
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      data_bus <= '0;
      data_bus_oe <= 1'b0;
    end else begin
      data_bus <= nxt_data;
      // no stale word on the bus in the cycle the start is taken
      data_bus_oe <= rd_active & ~start & (state_ff != adc_host_pkg::ST_CONVERT);
    end
  end

  // serial clock enable from a divider of the reference clock
  wire sclk_tick = (div_ff == DIV_W'(SCLK_DIV / 2 - 1));
  always_ff @(posedge ref_clk) begin
    if (reset | sclk_tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  // same serial frame for both start sources
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sclk_ff <= 1'b0;
      frame_ff <= 1'b0;
      bit_cnt_ff <= '0;
      shift_ff <= '0;
    end else if (start) begin
      frame_ff <= 1'b1;
      bit_cnt_ff <= '0;
      sclk_ff <= 1'b0;
      // zeros first; result bits taken from sample_code at the start edge
      shift_ff <= {{`SERIAL_LEAD_ZEROS{1'b0}}, sample_code};
    end else if (sclk_tick & (frame_ff | sclk_cont_ff)) begin
      sclk_ff <= ~sclk_ff;
      // data moves on rising clock so it is settled at the falling one
      if (frame_ff & ~sclk_ff & (bit_cnt_ff != '0)) begin
        shift_ff <= {shift_ff[`SERIAL_BITS-2:0], 1'b0};
      end
      if (frame_ff & sclk_ff) begin
        bit_cnt_ff <= bit_cnt_ff + 1'b1;
        if (bit_cnt_ff == 5'(`SERIAL_BITS - 1)) begin
          frame_ff <= 1'b0;
        end
      end
    end
  end

  // open drain: enable drives low; serial only in byte/serial format
  always_comb begin
    serial_out = '0;
    serial_oe.serial_frame_strobe_n = ~sync_ff.word_format & frame_ff;
    serial_oe.serial_clk = ~sync_ff.word_format & ~sclk_ff;
    serial_oe.serial_data = ~sync_ff.word_format & frame_ff & ~shift_ff[`SERIAL_BITS-1];
  end

endmodule // adc_conversion_host_interface
`default_nettype wire

// [rtl/adc_host_defines.svh]
// timing and field constants for the converter host interface
`ifndef ADC_HOST_DEFINES_SVH
`define ADC_HOST_DEFINES_SVH

`define CLK_PERIOD_NS 40
`define CONV_TIME_NS 8000
`define CONV_CYCLES ((`CONV_TIME_NS) / (`CLK_PERIOD_NS))
`define SCLK_DIV 8
`define SERIAL_BITS 16
`define SERIAL_LEAD_ZEROS 4
`define RESULT_BITS 12
`define BYTE_BITS 8

`endif

// [rtl/adc_host_pkg.sv]
// types shared by the converter host interface
package adc_host_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_DONE
  } conv_state_t;

  typedef struct packed {
    logic select_n;
    logic read_n;
    logic convert_start_n;
    logic high_byte_enable;
    logic word_format;
  } host_ctl_t;

  typedef struct packed {
    logic serial_frame_strobe_n;
    logic serial_clk;
    logic serial_data;
  } serial_out_t;

endpackage

// [bench/adc_host_sva.sv]
// assertion checker for the converter host interface
`timescale 1ns/1ns
`default_nettype none
module adc_host_sva #(
  parameter int CONV_CYCLES = 20
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // watched ports
  input wire adc_host_pkg::host_ctl_t host_ctl,
  input wire logic [11:0] data_bus,
  input wire logic data_bus_oe,
  input wire logic busy_int_n,
  input wire logic track_hold
);
  localparam int CMIN = CONV_CYCLES;
  localparam int CMAX = CONV_CYCLES + 1;
  int lo_cnt;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // length of each low phase of the status pin
  always_ff @(posedge ref_clk) begin
    if (reset || busy_int_n) begin
      lo_cnt <= 0;
    end else begin
      lo_cnt <= lo_cnt + 1;
    end
  end
  chk_busy_len: assert property ($rose(busy_int_n) && !host_ctl.convert_start_n |->
    lo_cnt inside {[CMIN:CMAX]}) else $error("busy low time wrong");
  chk_start_busy: assert property ($fell(host_ctl.select_n) && !host_ctl.convert_start_n
    && !host_ctl.high_byte_enable && busy_int_n && !track_hold |-> ##[2:4] !busy_int_n)
    else $error("no busy after start");
  chk_start_hold: assert property ($fell(host_ctl.select_n) && !host_ctl.convert_start_n
    && !host_ctl.high_byte_enable && !track_hold |-> ##[2:4] track_hold)
    else $error("no hold after start");
  chk_high_byte_enable_nostart: assert property ($fell(host_ctl.select_n) && host_ctl.high_byte_enable
    && busy_int_n && !track_hold |-> ##1 busy_int_n [*6]) else $error("upper read stretched");
  chk_top_nibble: assert property (data_bus_oe && !host_ctl.word_format
    && !$past(host_ctl.word_format, 4) |-> data_bus[11:8] == 4'h0) else $error("byte top");
  chk_hi_byte: assert property (data_bus_oe && !host_ctl.word_format
    && host_ctl.high_byte_enable && $past(host_ctl.high_byte_enable, 4)
    |-> data_bus[7:4] == 4'h0) else $error("upper byte not justified");
  chk_bus_quiet: assert property (track_hold && $past(track_hold) |-> !data_bus_oe)
    else $error("bus driven in conversion");
  chk_int_clear: assert property (!busy_int_n && host_ctl.convert_start_n
    && $fell(host_ctl.select_n) |-> ##[1:5] busy_int_n) else $error("interrupt not cleared");
  chk_timer_end: assert property ($fell(track_hold) && host_ctl.convert_start_n
    |-> ##[0:3] !busy_int_n) else $error("no end interrupt");
  cover property ($rose(busy_int_n) && !host_ctl.convert_start_n);
  cover property ($fell(busy_int_n) && host_ctl.convert_start_n);
  cover property (data_bus_oe && host_ctl.high_byte_enable);
endmodule // adc_host_sva
bind adc_conversion_host_interface adc_host_sva #(.CONV_CYCLES(CONV_CYCLES)) u_sva (
  .ref_clk(ref_clk), .reset(reset), .host_ctl(host_ctl), .data_bus(data_bus),
  .data_bus_oe(data_bus_oe), .busy_int_n(busy_int_n), .track_hold(track_hold));
`default_nettype wire

// [bench/host_model.sv]
// behavioural host processor on the parallel bus
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // clock
  input wire logic ref_clk,
  // pins toward the converter
  output var adc_host_pkg::host_ctl_t ctl,
  input wire logic busy_int_n,
  input wire logic [11:0] data_bus,
  // open-drain serial lines toward the receiving port
  input wire adc_host_pkg::serial_out_t ser_out,
  input wire adc_host_pkg::serial_out_t ser_oe
);
  int timeouts = 0;
  logic sclk_q, strb_q, dat_q;
  logic [15:0] rx_word;
  // pull-ups hold released lines high
  wire logic strb_line = ser_oe.serial_frame_strobe_n ? ser_out.serial_frame_strobe_n : 1'b1;
  wire logic sclk_line = ser_oe.serial_clk ? ser_out.serial_clk : 1'b1;
  wire logic data_line = ser_oe.serial_data ? ser_out.serial_data : 1'b1;
  // receiver takes the bit standing before each falling clock in a frame
  always @(posedge ref_clk) begin
    if (sclk_q && !sclk_line && !strb_q) begin
      rx_word <= {rx_word[14:0], dat_q};
    end
    sclk_q <= sclk_line;
    strb_q <= strb_line;
    dat_q <= data_line;
  end
  // deselected, convert start tied low for processor mode
  initial ctl = 5'h18;
  task rd(input logic hb, input logic wf, input logic cv, output logic [11:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    ctl <= '{1'b0, 1'b0, cv, hb, wf};
    repeat (4) @(posedge ref_clk);
    // wait states: access stays pending while busy
    while (!busy_int_n && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 100) timeouts++;
    repeat (3) @(posedge ref_clk);
    d = data_bus;
    ctl <= '{1'b1, 1'b1, cv, hb, wf};
    repeat (3) @(posedge ref_clk);
  endtask
  // timer-like rising start edge, left high; asynchronous to bus traffic
  task tstart();
    int n;
    n = 0;
    repeat (3) @(posedge ref_clk);
    ctl.convert_start_n <= 1'b1;
    while (busy_int_n && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    // reads come only after the end signal
    if (n >= 100) timeouts++;
  endtask
endmodule // host_model
`default_nettype wire

// [bench/adc_conversion_host_interface_tb.sv]
// testbench for the converter host interface
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_host_interface_tb;
  logic ref_clk, reset, data_bus_oe, busy_int_n, track_hold;
  logic [11:0] sample_code, data_bus, rd_val;
  adc_host_pkg::host_ctl_t host_ctl;
  adc_host_pkg::serial_out_t serial_out, serial_oe;
  int err_count, n_checks;
  adc_conversion_host_interface #(.CONV_CYCLES(20)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .host_ctl(host_ctl), .sample_code(sample_code),
    .data_bus(data_bus), .data_bus_oe(data_bus_oe), .busy_int_n(busy_int_n),
    .track_hold(track_hold), .serial_out(serial_out), .serial_oe(serial_oe),
    .sclk_continuous(1'b0));
  host_model u_host (.ref_clk(ref_clk), .ctl(host_ctl), .busy_int_n(busy_int_n),
    .data_bus(data_bus), .ser_out(serial_out), .ser_oe(serial_oe));
  task check(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // whole run needs a few hundred cycles
  initial begin
    #100000;
    err_count++;
    summarize();
  end
  initial begin
    err_count = 0;
    n_checks = 0;
    reset = 1'b1;
    sample_code = 12'hA5C;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    u_host.rd(1'b0, 1'b1, 1'b0, rd_val);
    check(rd_val, 12'hA5C);
    check({11'h000, busy_int_n}, 12'h001);
    sample_code <= 12'h3E7;
    u_host.rd(1'b0, 1'b0, 1'b0, rd_val);
    check(rd_val, 12'h0E7);
    u_host.rd(1'b1, 1'b0, 1'b0, rd_val);
    check(rd_val, 12'h003);
    // let the processor-started serial frame run out
    repeat (110) @(posedge ref_clk);
    check({8'h00, u_host.rx_word[15:12]}, 12'h000);
    check(u_host.rx_word[11:0], 12'h3E7);
    sample_code <= 12'h5A1;
    u_host.tstart();
    repeat (120) @(posedge ref_clk);
    check({11'h000, busy_int_n}, 12'h000);
    check({8'h00, u_host.rx_word[15:12]}, 12'h000);
    check(u_host.rx_word[11:0], 12'h5A1);
    u_host.rd(1'b0, 1'b1, 1'b1, rd_val);
    check(rd_val, 12'h5A1);
    check({11'h000, busy_int_n}, 12'h001);
    check(u_host.timeouts[11:0], 12'h000);
    summarize();
  end
endmodule // adc_conversion_host_interface_tb
`default_nettype wire
